/* File: src/timer_consts.vh */
// Constants for the 16-bit capture/reload timer: register map, fields, timing.
// Assumes a 50 MHz core clock standing in for the oscillator.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register offsets on the plain register port
`define REG_CONTROL      4'h0
`define REG_MODE         4'h1
`define REG_COUNT_LOW    4'h2
`define REG_COUNT_HIGH   4'h3
`define REG_RELOAD_LOW   4'h4
`define REG_RELOAD_HIGH  4'h5

// Control and mode register field positions
`define CTL_OVF_BIT      7
`define CTL_EXT_BIT      6
`define CTL_RXB_BIT      5
`define CTL_TXB_BIT      4
`define CTL_EDGE_BIT     3
`define CTL_RUN_BIT      2
`define CTL_CNT_BIT      1
`define CTL_CAP_BIT      0
`define MODE_DOWN_BIT    0

// Reset values and the 16-bit all-ones count
`define CONTROL_RESET    8'h00
`define MODE_RESET       1'b0
`define ZERO_BYTE        8'h00
`define ALL_ONES_16      16'hFFFF

// Oscillator periods per machine cycle and per state time
`define OSC_PER_MACHINE  4'd12
`define OSC_PER_STATE    4'd2
`define MACHINE_LAST     4'd11
`define STATE_LAST       1'b1

`endif

/* File: src/timer_phase_gen.v */
// Phase generator: one-cycle enables for machine cycles and state times.
// Assumes every core clock edge is one oscillator period.
`timescale 1ns/1ns
`include "timer_consts.vh"

module timer_phase_gen (
	input  wire ref_clk_i,
	input  wire reset_n_i,
	output reg  machine_tick_o,
	output reg  state_tick_o
);

	reg [3:0] osc_cnt_ff;
	reg       state_cnt_ff;

	////////////////////////////////////////////////////////////////////////////
	// Divide by twelve and by two
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			osc_cnt_ff     <= 4'h0;
			state_cnt_ff   <= 1'b0;
			machine_tick_o <= 1'b0;
			state_tick_o   <= 1'b0;
		end else begin
			machine_tick_o <= (osc_cnt_ff == `MACHINE_LAST);
			state_tick_o   <= (state_cnt_ff == `STATE_LAST);
			state_cnt_ff   <= ~state_cnt_ff;
			if (osc_cnt_ff == `MACHINE_LAST)
				osc_cnt_ff <= 4'h0;
			else
				osc_cnt_ff <= osc_cnt_ff + 4'h1;
		end
	end

endmodule // timer_phase_gen

/* File: src/timer_edge_sampler.v */
// Pin sampler: two-flop synchroniser, then a per-machine-cycle sample that
// reports a high sample followed by a low one as a single falling edge.
// Assumes sample_en_i is a one-cycle enable from the phase generator.
`timescale 1ns/1ns
`include "timer_consts.vh"

module timer_edge_sampler (
	input  wire ref_clk_i,
	input  wire reset_n_i,
	input  wire pin_i,
	input  wire sample_en_i,
	output wire level_o,
	output reg  fall_o
);

	reg sync1_ff;
	reg sync2_ff;
	reg sample_ff;

	assign level_o = sync2_ff;

	////////////////////////////////////////////////////////////////////////////
	// Synchronise, sample once per machine cycle, compare to last sample
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync1_ff  <= 1'b0;
			sync2_ff  <= 1'b0;
			sample_ff <= 1'b0;
			fall_o    <= 1'b0;
		end else begin
			sync1_ff <= pin_i;
			sync2_ff <= sync1_ff;
			fall_o   <= 1'b0;
			if (sample_en_i) begin
				sample_ff <= sync2_ff;
				fall_o    <= sample_ff & ~sync2_ff;
			end
		end
	end

endmodule // timer_edge_sampler

/* File: src/timer_counter_capture_reload.v */
// Top of the 16-bit timer/event counter with capture, auto-reload and baud mode.
// Assumes a single-cycle register port, pins from outside the clock domain,
// and that the serial port consumes the rollover pulse in baud mode.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`include "timer_consts.vh"

// How it works
// - counter_select picks timer or event counting
// - run, capture select, baud bits choose mode
// - timer function counts once per machine cycle
// - count input sampled each cycle, falling edge counts
// - edge counting limited to once per two cycles
// - capture without edge enable: overflow sets flag
// - capture trigger edge copies count, sets event flag
// - capture event flag raises interrupt if down enable is low
// - down enable resets low; direction from trigger pin
// - up reload mode reloads at all-ones overflow
// - trigger edge with enable also reloads
// - up/down mode, trigger high counts up, reloads
// - down count underflows at reload value, loads ones
// - event flag toggles on wrap, no interrupt
// - overflow flag set by hardware, cleared by software
// - baud selects force auto-reload on overflow
// - baud mode counts per state, no overflow flag
// - interrupt is OR of overflow flag and event flag gated by down enable low
module timer_counter_capture_reload (
	input  wire       ref_clk_i,
	input  wire       reset_n_i,
	input  wire [3:0] addr_i,
	input  wire [7:0] wdata_i,
	input  wire       wr_i,
	input  wire       rd_i,
	output reg  [7:0] rdata_o,
	input  wire       count_input_pin_i,
	input  wire       ext_trigger_pin_i,
	output reg        timer_irq_o,
	output reg        baud_tick_o
);

	reg        timer_overflow_flag_ff;
	reg        external_event_flag_ff;
	reg        rx_baud_select_ff;
	reg        tx_baud_select_ff;
	reg        external_edge_enable_ff;
	reg        run_control_ff;
	reg        counter_select_ff;
	reg        capture_reload_select_ff;
	reg        down_count_enable_ff;
	reg  [7:0] count_low_byte_ff;
	reg  [7:0] count_high_byte_ff;
	reg  [7:0] reload_low_byte_ff;
	reg  [7:0] reload_high_byte_ff;
	reg        count_fall_ff;

	wire       machine_tick;
	wire       state_tick;
	wire       count_fall;
	wire       trig_fall;
	wire       trig_level;

	////////////////////////////////////////////////////////////////////////////
	// Timing and pin samplers
	timer_phase_gen u_phase (
		.ref_clk_i      (ref_clk_i),
		.reset_n_i      (reset_n_i),
		.machine_tick_o (machine_tick),
		.state_tick_o   (state_tick)
	);

	timer_edge_sampler u_count_pin (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.pin_i       (count_input_pin_i),
		.sample_en_i (machine_tick),
		.level_o     (),
		.fall_o      (count_fall)
	);

	timer_edge_sampler u_trig_pin (
		.ref_clk_i   (ref_clk_i),
		.reset_n_i   (reset_n_i),
		.pin_i       (ext_trigger_pin_i),
		.sample_en_i (machine_tick),
		.level_o     (trig_level),
		.fall_o      (trig_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire [15:0] count_val  = {count_high_byte_ff, count_low_byte_ff};
	wire [15:0] reload_val = {reload_high_byte_ff, reload_low_byte_ff};
	wire baud_mode   = rx_baud_select_ff | tx_baud_select_ff;
	wire capture_md  = run_control_ff & ~baud_mode & capture_reload_select_ff;
	wire reload_md   = run_control_ff & ~baud_mode & ~capture_reload_select_ff;
	wire updown_md   = reload_md & down_count_enable_ff;
	wire count_up    = ~updown_md | trig_level;
	wire edge_active = external_edge_enable_ff & ~updown_md;

	// Count enable: state time in baud timer mode, machine cycle in timer mode,
	// a detected falling edge one machine cycle later in counter mode
	reg step;
	always @* begin
		if (!run_control_ff)
			step = 1'b0;
		else if (counter_select_ff)
			step = count_fall_ff & machine_tick;
		else if (baud_mode)
			step = state_tick;
		else
			step = machine_tick;
	end

	wire wrap_up   = step & count_up & (count_val == `ALL_ONES_16);
	wire wrap_down = step & ~count_up & (count_val == reload_val);
	wire wrapped   = wrap_up | wrap_down;

	// Bus write decode helper
	function wr_hit;
		input [3:0] a;
		input [3:0] target;
		input       w;
		begin
			wr_hit = w & (a == target);
		end
	endfunction

	wire wr_ctl    = wr_hit(addr_i, `REG_CONTROL, wr_i);
	wire wr_mode   = wr_hit(addr_i, `REG_MODE, wr_i);
	wire wr_cnt_lo = wr_hit(addr_i, `REG_COUNT_LOW, wr_i);
	wire wr_cnt_hi = wr_hit(addr_i, `REG_COUNT_HIGH, wr_i);
	wire wr_rl_lo  = wr_hit(addr_i, `REG_RELOAD_LOW, wr_i);
	wire wr_rl_hi  = wr_hit(addr_i, `REG_RELOAD_HIGH, wr_i);

	// Trigger edge that takes effect, honoured in any running mode except up/down
	wire trig_event = trig_fall & edge_active & run_control_ff;

	////////////////////////////////////////////////////////////////////////////
	// Hold a counter-mode edge until the next machine cycle update
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			count_fall_ff <= 1'b0;
		else if (count_fall)
			count_fall_ff <= 1'b1;
		else if (machine_tick)
			count_fall_ff <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and mode registers; flags set by hardware win over clears
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer_overflow_flag_ff   <= 1'b0;
			external_event_flag_ff   <= 1'b0;
			rx_baud_select_ff        <= 1'b0;
			tx_baud_select_ff        <= 1'b0;
			external_edge_enable_ff  <= 1'b0;
			run_control_ff           <= 1'b0;
			counter_select_ff        <= 1'b0;
			capture_reload_select_ff <= 1'b0;
			down_count_enable_ff     <= `MODE_RESET;
		end else begin
			if (wr_ctl) begin
				timer_overflow_flag_ff   <= wdata_i[`CTL_OVF_BIT];
				external_event_flag_ff   <= wdata_i[`CTL_EXT_BIT];
				rx_baud_select_ff        <= wdata_i[`CTL_RXB_BIT];
				tx_baud_select_ff        <= wdata_i[`CTL_TXB_BIT];
				external_edge_enable_ff  <= wdata_i[`CTL_EDGE_BIT];
				run_control_ff           <= wdata_i[`CTL_RUN_BIT];
				counter_select_ff        <= wdata_i[`CTL_CNT_BIT];
				capture_reload_select_ff <= wdata_i[`CTL_CAP_BIT];
			end
			if (wr_mode)
				down_count_enable_ff <= wdata_i[`MODE_DOWN_BIT];
			// Overflow flag: never in baud mode, set wins over clear
			if (wrapped & ~baud_mode)
				timer_overflow_flag_ff <= 1'b1;
			// Event flag: toggles as 17th bit in up/down, else set by edges
			if (updown_md & wrapped)
				external_event_flag_ff <= ~external_event_flag_ff;
			else if (trig_event)
				external_event_flag_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Count bytes: step, reload and software writes
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_low_byte_ff  <= `ZERO_BYTE;
			count_high_byte_ff <= `ZERO_BYTE;
		end else if (wrapped & ~capture_md) begin
			if (wrap_down)
				{count_high_byte_ff, count_low_byte_ff} <= `ALL_ONES_16;
			else
				{count_high_byte_ff, count_low_byte_ff} <= reload_val;
		end else if (trig_event & reload_md) begin
			{count_high_byte_ff, count_low_byte_ff} <= reload_val;
		end else if (step) begin
			if (count_up)
				{count_high_byte_ff, count_low_byte_ff} <= count_val + 16'h0001;
			else
				{count_high_byte_ff, count_low_byte_ff} <= count_val - 16'h0001;
		end else begin
			if (wr_cnt_lo)
				count_low_byte_ff <= wdata_i;
			if (wr_cnt_hi)
				count_high_byte_ff <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture/reload bytes: capture on trigger edge, else software writes
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			reload_low_byte_ff  <= `ZERO_BYTE;
			reload_high_byte_ff <= `ZERO_BYTE;
		end else if (trig_event & capture_md) begin
			reload_low_byte_ff  <= count_low_byte_ff;
			reload_high_byte_ff <= count_high_byte_ff;
		end else begin
			if (wr_rl_lo)
				reload_low_byte_ff <= wdata_i;
			if (wr_rl_hi)
				reload_high_byte_ff <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt request and baud rollover pulse
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			timer_irq_o <= 1'b0;
			baud_tick_o <= 1'b0;
		end else begin
			// Event flag masked whenever the down count enable is set
			timer_irq_o <= timer_overflow_flag_ff |
				(external_event_flag_ff & ~down_count_enable_ff);
			baud_tick_o <= wrap_up & baud_mode;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port: data the cycle after the strobe, zero for unmapped
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rdata_o <= `ZERO_BYTE;
		else if (rd_i) begin
			case (addr_i)
				`REG_CONTROL: rdata_o <= {timer_overflow_flag_ff, external_event_flag_ff,
					rx_baud_select_ff, tx_baud_select_ff, external_edge_enable_ff,
					run_control_ff, counter_select_ff, capture_reload_select_ff};
				`REG_MODE:        rdata_o <= {7'h00, down_count_enable_ff};
				`REG_COUNT_LOW:   rdata_o <= count_low_byte_ff;
				`REG_COUNT_HIGH:  rdata_o <= count_high_byte_ff;
				`REG_RELOAD_LOW:  rdata_o <= reload_low_byte_ff;
				`REG_RELOAD_HIGH: rdata_o <= reload_high_byte_ff;
				default:          rdata_o <= `ZERO_BYTE;
			endcase
		end else
			rdata_o <= `ZERO_BYTE;
	end

endmodule // timer_counter_capture_reload

/* File: testbench/timer_chk.sv */
// Port checker for the capture/reload timer.
// Assumes one-cycle strobes and the control/mode register map.
`timescale 1ns/1ns
module timer_chk (
	input wire       ref_clk_i,
	input wire       reset_n_i,
	input wire [3:0] addr_i,
	input wire [7:0] wdata_i,
	input wire       wr_i,
	input wire       rd_i,
	input wire [7:0] rdata_o,
	input wire       timer_irq_o,
	input wire       baud_tick_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadow of the baud select bits
	reg baud_ff;
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			baud_ff <= 1'b0;
		else if (wr_i && addr_i == 4'h0)
			baud_ff <= |wdata_i[5:4];
	end
	////////////////////////////////////////////////////////////
	property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
	property p_rd_unmapped; rd_i && addr_i > 4'h5 |=> rdata_o == 8'h00; endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read");
	property p_ctl_rb; wr_i && addr_i == 4'h0 ##1 rd_i && addr_i == 4'h0
		|=> rdata_o[5:0] == $past(wdata_i[5:0], 2); endproperty
	a_ctl_rb: assert property (p_ctl_rb) else $error("control bits lost");
	property p_mode_rb; wr_i && addr_i == 4'h1 ##1 rd_i && addr_i == 4'h1
		|=> rdata_o[0] == $past(wdata_i[0], 2); endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("down enable lost");
	property p_irq_hold; timer_irq_o && !wr_i && !$past(wr_i) |=> timer_irq_o; endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("flag cleared alone");
	property p_irq_fall; $fell(timer_irq_o) |-> $past(wr_i, 2) || $past(wr_i, 3); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell unasked");
	property p_baud_pulse; baud_tick_o |=> !baud_tick_o; endproperty
	a_baud_pulse: assert property (p_baud_pulse) else $error("long baud tick");
	property p_baud_mode; baud_tick_o |-> baud_ff || $past(baud_ff) || $past(baud_ff, 2);
	endproperty
	a_baud_mode: assert property (p_baud_mode) else $error("tick off baud");
	// Main scenarios reached
	c_baud: cover property (baud_tick_o);
	c_irq: cover property ($rose(timer_irq_o));
	c_evt: cover property (rd_i && addr_i == 4'h0 ##1 rdata_o[6]);
endmodule // timer_chk

bind timer_counter_capture_reload timer_chk u_chk (
	.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_irq_o(timer_irq_o),
	.baud_tick_o(baud_tick_o));

/* File: testbench/pin_model.sv */
// External sources on the count and trigger pins.
// Assumes tasks are called just after a clock edge.
`timescale 1ns/1ns
module pin_model (
	input  wire ref_clk_i,
	output reg  count_pin_o,
	output reg  trig_pin_o
);
	// Both pins idle high, as with port pull-ups
	initial begin
		count_pin_o = 1'b1;
		trig_pin_o  = 1'b1;
	end
	// Put one pin at a level and keep it for some clocks
	task hold_lvl(input bit trig, input bit lvl, input int hold);
		if (trig)
			trig_pin_o <= lvl;
		else
			count_pin_o <= lvl;
		repeat (hold) @(posedge ref_clk_i);
	endtask
	// Falling pulses, each level kept for hold clocks
	task pulses(input bit trig, input int n, input int hold);
		repeat (n) begin
			hold_lvl(trig, 1'b0, hold);
			hold_lvl(trig, 1'b1, hold);
		end
	endtask
endmodule // pin_model

/* File: testbench/testbench.sv */
// Self-checking bench for the capture/reload timer.
// Assumes the pin model drives both external pins.
`timescale 1ns/1ns
module testbench;
	reg         ref_clk_i = 1'b0;
	reg         reset_n_i = 1'b0;
	reg         wr_i      = 1'b0;
	reg         rd_i      = 1'b0;
	reg  [3:0]  addr_i    = 4'h0;
	reg  [7:0]  wdata_i   = 8'h00;
	reg  [7:0]  rv;
	reg  [15:0] c;
	wire [7:0]  rdata_o;
	wire        cnt_pin, trig_pin, timer_irq_o, baud_tick_o;
	int         failures = 0;
	int         n_compared = 0;
	time        rise_q[$];
	time        bq[$];
	// Clock and event time stamps
	initial forever #10 ref_clk_i = ~ref_clk_i;
	always @(posedge timer_irq_o) rise_q.push_back($time);
	always @(posedge baud_tick_o) bq.push_back($time);
	timer_counter_capture_reload dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.count_input_pin_i(cnt_pin), .ext_trigger_pin_i(trig_pin),
		.timer_irq_o(timer_irq_o), .baud_tick_o(baud_tick_o));
	pin_model pm (.ref_clk_i(ref_clk_i), .count_pin_o(cnt_pin), .trig_pin_o(trig_pin));
	////////////////////////////////////////////////////////////
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One strobe cycle; read data kept in rv
	task bus(input bit w, input [3:0] a, input [7:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= w;
		rd_i    <= !w;
		@(posedge ref_clk_i);
		wr_i    <= 1'b0;
		rd_i    <= 1'b0;
		#1 rv = rdata_o;
	endtask
	task rd(input [3:0] a, input [7:0] e);
		bus(1'b0, a, 8'h00);
		chk({8'h00, rv}, {8'h00, e});
	endtask
	task set16(input [3:0] a, input [15:0] d);
		bus(1'b1, a, d[7:0]);
		bus(1'b1, a + 4'h1, d[15:8]);
	endtask
	task wait_rise(input int n);
		for (int k = 0; k < 400 && rise_q.size() < n; k++)
			cyc(1);
		chk(16'(rise_q.size() >= n), 16'h0001);
	endtask
	task test_done;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(50811));
		repeat (12) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		cyc(1);
		// Reset values and unmapped places, then readback
		for (int k = 0; k < 8; k++)
			rd(4'(k), 8'h00);
		c = 16'($urandom);
		set16(4'h4, c);
		rd(4'h4, c[7:0]);
		rd(4'h5, c[15:8]);
		bus(1'b1, 4'h0, 8'h03);
		rd(4'h0, 8'h03);
		bus(1'b1, 4'h1, 8'h01);
		rd(4'h1, 8'h01);
		bus(1'b1, 4'h1, 8'h00);
		// Timer function: two steps between reloads
		set16(4'h4, 16'hFFFE);
		set16(4'h2, 16'hFFFF);
		rise_q.delete();
		bus(1'b1, 4'h0, 8'h04);
		wait_rise(1);
		bus(1'b1, 4'h0, 8'h04);
		wait_rise(2);
		bus(1'b1, 4'h0, 8'h80);
		chk(16'((rise_q[1] - rise_q[0]) / 20), 16'd24);
		rd(4'h0, 8'h80);
		rd(4'h2, 8'hFE);
		rd(4'h3, 8'hFF);
		bus(1'b1, 4'h0, 8'h00);
		cyc(3);
		chk(16'(timer_irq_o), 16'h0000);
		// Counter function: five pulses at the fastest legal rate
		set16(4'h2, 16'h0000);
		bus(1'b1, 4'h0, 8'h06);
		cyc(50);
		rd(4'h2, 8'h00);
		pm.pulses(1'b0, 5, 12);
		cyc(40);
		rd(4'h2, 8'h05);
		// Capture of a random count on a trigger fall
		c = 16'($urandom) & 16'h7F00;
		set16(4'h2, c);
		rise_q.delete();
		bus(1'b1, 4'h0, 8'h0D);
		pm.hold_lvl(1'b1, 1'b0, 1);
		wait_rise(1);
		bus(1'b1, 4'h0, 8'h49);
		pm.hold_lvl(1'b1, 1'b1, 12);
		rd(4'h0, 8'h49);
		rd(4'h5, c[15:8]);
		bus(1'b0, 4'h4, 8'h00);
		c[7:0] = rv;
		bus(1'b0, 4'h2, 8'h00);
		chk(16'(rv - c[7:0] < 8'd2), 16'h0001);
		// Up/down: down to the reload value, then up past all ones
		bus(1'b1, 4'h1, 8'h01);
		set16(4'h4, 16'h0010);
		set16(4'h2, 16'h0011);
		pm.hold_lvl(1'b1, 1'b0, 1);
		rise_q.delete();
		bus(1'b1, 4'h0, 8'h04);
		wait_rise(1);
		rd(4'h0, 8'hC4);
		rd(4'h2, 8'hFF);
		rd(4'h3, 8'hFF);
		bus(1'b1, 4'h0, 8'h44);
		cyc(3);
		chk(16'(timer_irq_o), 16'h0000);
		pm.hold_lvl(1'b1, 1'b1, 1);
		wait_rise(2);
		rd(4'h0, 8'h84);
		rd(4'h2, 8'h10);
		rd(4'h3, 8'h00);
		bus(1'b1, 4'h0, 8'h00);
		bus(1'b1, 4'h1, 8'h00);
		// Baud mode: rollover every three state times
		set16(4'h4, 16'hFFFD);
		set16(4'h2, 16'hFFFD);
		rise_q.delete();
		bus(1'b1, 4'h0, 8'h1C);
		cyc(30);
		chk(16'((bq[1] - bq[0]) / 20), 16'd6);
		chk(16'(timer_irq_o), 16'h0000);
		pm.hold_lvl(1'b1, 1'b0, 1);
		wait_rise(1);
		rd(4'h0, 8'h5C);
		bus(1'b1, 4'h0, 8'h00);
		test_done;
	end
	// Watchdog against a hang
	initial begin
		#(20 * 5000);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done;
	end
endmodule // testbench
